// *** core/jtg_pkg.sv ***
package jtg_pkg;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned NUM_GATES   = 4;

    // register byte offsets
    localparam logic [7:0] OFF_GATE     = 8'h00;
    localparam logic [7:0] OFF_PORT     = 8'h04;
    localparam logic [7:0] OFF_TAMPER   = 8'h08;
    localparam logic [7:0] OFF_STATUS   = 8'h0C;
    localparam logic [7:0] OFF_INT_STAT = 8'h10;
    localparam logic [7:0] OFF_INT_MASK = 8'h14;

    // gate bit positions
    localparam int unsigned GATE_TAP    = 0;
    localparam int unsigned GATE_DAP    = 1;
    localparam int unsigned GATE_CFG    = 2;
    localparam int unsigned GATE_USER   = 3;

    // tamper configuration fields
    localparam int unsigned TCFG_DET_EN = 0;
    localparam int unsigned TCFG_RESP   = 1;
    localparam int unsigned TCFG_LOCK   = 2;
    localparam int unsigned TCFG_W      = 3;

    // status fields
    localparam int unsigned ST_ALERT    = 0;
    localparam int unsigned ST_PORT     = 1;
    localparam int unsigned ST_FUSE     = 2;
    localparam int unsigned ST_LOCK     = 3;
    localparam int unsigned ST_GATES    = 4;

    // interrupt events
    localparam int unsigned EV_ALERT    = 0;
    localparam int unsigned EV_RESP     = 1;
    localparam int unsigned EV_W        = 2;

    // reset values
    localparam logic [3:0] GATE_RESET   = 4'hF;
    localparam logic [2:0] TCFG_RESET   = 3'h0;
    localparam logic [1:0] MASK_RESET   = 2'h0;

    // detector needs this many qualifying test-clock rises
    localparam logic [1:0] DET_RISES    = 2'h3;
    // cycles after reset release in which the boot strap is taken;
    // must exceed the pin synchroniser latency, which is reset as well
    localparam logic [2:0] STRAP_CYCLES = 3'h6;
    localparam int unsigned SYNC_W      = 5;
endpackage

// *** core/jtg_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; the output follows only when stages two and
// three agree, so a single metastable sample is never passed on
module jtg_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1[i]   <= 1'b0;
                    s2[i]   <= 1'b0;
                    s3[i]   <= 1'b0;
                    dout[i] <= 1'b0;
                end else if (ce) begin
                    s1[i] <= din[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        dout[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** core/jtg_toggle_det.sv ***
`timescale 1ns/1ps
`default_nettype none
module jtg_toggle_det (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       enable,
    input  wire logic       tck_rise,
    input  wire logic       active,
    output logic      [1:0] run_count,
    output logic            alert
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_count <= 2'h0;
        end else if (ce) begin
            if (!enable || alert) begin
                run_count <= 2'h0;
            end else if (tck_rise) begin
                if (active) begin
                    run_count <= run_count + 2'h1;
                end else begin
                    run_count <= 2'h0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert <= 1'b0;
        end else if (ce) begin
            if (enable && tck_rise && active &&
                run_count == jtg_pkg::DET_RISES - 2'h1) begin
                alert <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** core/jtg_gate_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - test port starts disabled; boot or software opens it
// - gate bits reset to gating state
// - data or mode activity with running clock alerts
// - alert sticky until power-on reset
// - three qualifying clock rises before alert
// - tamper response only when response programmed
// - any opened gate suppresses the detector
// - gated chain hides user debug logic
// - lockdown response tristates all general outputs
// - detector runs only when its enable set
// - disable fuse forces gates, bypass, reset-only identification
module jtg_gate_top (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   test_clk,
    input  wire logic                   test_data_in,
    input  wire logic                   test_mode_sel,
    input  wire logic                   boot_nonsecure,
    input  wire logic                   fuse_port_disable,
    input  wire logic                   tap_in_reset,
    input  wire logic                   tap_ir_load,
    output logic      [3:0]             path_open,
    output logic                        user_debug_reach,
    output logic                        force_bypass,
    output logic                        id_available,
    output logic                        tamper_alert,
    output logic                        tamper_response,
    output logic                        global_output_tristate,
    output logic                        irq
);
    logic [4:0] pins_sync;
    logic       tck_s;
    logic       tdi_s;
    logic       tms_s;
    logic       boot_ns_s;
    logic       fuse_s;
    logic       tck_prev;
    logic       tck_rise;
    logic [1:0] run_count;
    logic       alert;
    logic       alert_seen;
    logic       alert_rise;
    logic       det_en;
    logic [3:0] gate;
    logic [3:0] gate_eff;
    logic       port_en;
    logic [2:0] strap_cnt;
    logic [2:0] tcfg;
    logic       lockdown;
    logic       id_ok;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic [1:0] events;
    logic       wr_en;
    logic       rd_setup;
    logic       addr_ok;
    logic       next_slverr;
    logic [31:0] next_rdata;

    // test pins, boot strap and fuse pass the synchroniser first; tap_in_reset and tap_ir_load do not
    jtg_sync #(
        .W (jtg_pkg::SYNC_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     ({fuse_port_disable, boot_nonsecure, test_mode_sel,
                   test_data_in, test_clk}),
        .dout    (pins_sync)
    );

    assign tck_s     = pins_sync[0];
    assign tdi_s     = pins_sync[1];
    assign tms_s     = pins_sync[2];
    assign boot_ns_s = pins_sync[3];
    assign fuse_s    = pins_sync[4];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_prev <= 1'b0;
        end else if (ce) begin
            tck_prev <= tck_s;
        end
    end

    assign tck_rise = tck_s && !tck_prev;

    // fuse holds every gate in gating state
    assign gate_eff = fuse_s ? jtg_pkg::GATE_RESET : gate;

    // detector off when any gate opened
    // detector gated by its enable bit
    assign det_en = tcfg[jtg_pkg::TCFG_DET_EN] && (&gate_eff);

    // data-in or mode-select high on a clock rise
    jtg_toggle_det u_det (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .enable    (det_en),
        .tck_rise  (tck_rise),
        .active    (tdi_s || tms_s),
        .run_count (run_count),
        .alert     (alert)
    );

    assign tamper_alert = alert;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_seen <= 1'b0;
        end else if (ce) begin
            alert_seen <= alert;
        end
    end

    assign alert_rise = alert && !alert_seen;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tamper_response <= 1'b0;
        end else if (ce) begin
            tamper_response <= alert_rise && tcfg[jtg_pkg::TCFG_RESP];
        end
    end

    // lockdown latches and tristates general outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lockdown <= 1'b0;
        end else if (ce) begin
            if (tamper_response && tcfg[jtg_pkg::TCFG_LOCK]) begin
                lockdown <= 1'b1;
            end
        end
    end

    assign global_output_tristate = lockdown;

    // strap taken only in a short window after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt <= 3'h0;
        end else if (ce && strap_cnt != jtg_pkg::STRAP_CYCLES) begin
            strap_cnt <= strap_cnt + 3'h1;
        end
    end

    assign wr_en    = psel && penable && pwrite && ce;
    assign rd_setup = psel && !penable && ce;

    always_comb begin
        addr_ok = 1'b1;
        case (paddr)
            jtg_pkg::OFF_GATE,
            jtg_pkg::OFF_PORT,
            jtg_pkg::OFF_TAMPER,
            jtg_pkg::OFF_STATUS,
            jtg_pkg::OFF_INT_STAT,
            jtg_pkg::OFF_INT_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // port closed at reset, opened by boot or software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_en <= 1'b0;
        end else if (ce) begin
            if (fuse_s) begin
                port_en <= 1'b0;
            end else if (boot_ns_s &&
                         strap_cnt == jtg_pkg::STRAP_CYCLES - 3'h1) begin
                port_en <= 1'b1;
            end else if (wr_en && paddr == jtg_pkg::OFF_PORT) begin
                port_en <= pwdata[0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate <= jtg_pkg::GATE_RESET;
        end else if (wr_en && paddr == jtg_pkg::OFF_GATE) begin
            gate <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcfg <= jtg_pkg::TCFG_RESET;
        end else if (wr_en && paddr == jtg_pkg::OFF_TAMPER) begin
            tcfg <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= jtg_pkg::MASK_RESET;
        end else if (wr_en && paddr == jtg_pkg::OFF_INT_MASK) begin
            int_mask <= pwdata[1:0];
        end
    end

    assign events = {tamper_response, alert_rise};

    // a new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat <= 2'h0;
        end else if (ce) begin
            if (wr_en && paddr == jtg_pkg::OFF_INT_STAT) begin
                int_stat <= (int_stat & ~pwdata[1:0]) | events;
            end else begin
                int_stat <= int_stat | events;
            end
        end
    end

    assign irq = |(int_stat & int_mask);

    // user debug reachable only through an open gate
    assign path_open        = port_en ? ~gate_eff : 4'h0;
    assign user_debug_reach = path_open[jtg_pkg::GATE_USER];

    // every instruction becomes bypass while fuse blown
    assign force_bypass = fuse_s;

    // while fused, identification only once the tap passed reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_ok <= 1'b0;
        end else if (ce) begin
            if (tap_in_reset) begin
                id_ok <= 1'b1;
            end else if (tap_ir_load) begin
                id_ok <= 1'b0;
            end
        end
    end

    assign id_available = !fuse_s || id_ok;

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            jtg_pkg::OFF_GATE: next_rdata[3:0] = gate_eff;
            jtg_pkg::OFF_PORT: next_rdata[0] = port_en;
            jtg_pkg::OFF_TAMPER: next_rdata[2:0] = tcfg;
            jtg_pkg::OFF_STATUS: begin
                next_rdata[jtg_pkg::ST_ALERT] = alert;
                next_rdata[jtg_pkg::ST_PORT]  = port_en;
                next_rdata[jtg_pkg::ST_FUSE]  = fuse_s;
                next_rdata[jtg_pkg::ST_LOCK]  = lockdown;
                next_rdata[7:4]               = gate_eff;
            end
            jtg_pkg::OFF_INT_STAT: next_rdata[1:0] = int_stat;
            jtg_pkg::OFF_INT_MASK: next_rdata[1:0] = int_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
        next_slverr = !addr_ok;
    end

    // read data and error are captured in setup, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= next_slverr;
        end
    end

    // a frozen block stalls the access phase; a read set up while frozen returns the old read data and error
    assign pready = ce;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_alert_rise;
        ce && !alert ##1 alert;
    endsequence

    sequence s_qual_third;
        tck_rise && (tdi_s || tms_s) && det_en && run_count == 2'h2;
    endsequence

    a_alert_sticky: assert property (alert |=> alert)
        else $error("tamper alert dropped without reset");
    a_three_rises: assert property (
        ce && !alert ##1 alert |-> $past(run_count) == 2'h2)
        else $error("alert raised before three clock rises");
    a_alert_cause: assert property (
        s_qual_third ##0 (ce && !alert) |=> alert)
        else $error("qualifying activity did not raise alert");
    a_det_gated: assert property (
        s_alert_rise |-> $past(&gate_eff))
        else $error("alert raised while a gate was open");
    a_det_enable: assert property (
        s_alert_rise |-> $past(tcfg[0]))
        else $error("alert raised with detector disabled");
    a_resp_prog: assert property (
        tamper_response |-> $past(tcfg[1]) && $past(alert_rise))
        else $error("response without programmed setting");
    a_lock_follow: assert property (
        ce && tamper_response && tcfg[2] |=> global_output_tristate)
        else $error("lockdown did not tristate outputs");
    a_port_closed: assert property (!port_en |-> path_open == 4'h0)
        else $error("path open while port disabled");
    a_user_hidden: assert property (
        gate_eff[3] |-> !user_debug_reach)
        else $error("user debug reachable through closed gate");
    a_fuse_force: assert property (
        fuse_s |-> gate_eff == 4'hF && force_bypass && path_open == 4'h0)
        else $error("fuse did not force gates and bypass");
    a_gate_write: assert property (
        wr_en && paddr == 8'h00 |=> gate == $past(pwdata[3:0]))
        else $error("gate register did not take write");
endmodule
`default_nettype wire

// *** verif/jtg_probe.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural boundary-scan tester: one frame of test clock rises,
// 8 pclk per period, clock still and data lines wandering between frames
module jtg_probe (
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic [3:0] n_rises,
    input  wire logic [7:0] qual,
    input  wire logic       use_tdi,
    output logic            test_clk,
    output logic            test_data_in,
    output logic            test_mode_sel,
    output logic            busy
);
    logic [2:0] ph;
    logic [3:0] k;

    initial begin
        test_clk = 1'b0;
        test_data_in = 1'b0;
        test_mode_sel = 1'b0;
        busy = 1'b0;
        ph = 3'h0;
        k = 4'h0;
    end

    always @(posedge pclk) begin
        if (!busy) begin
            // lines are not held idle, so a stale level never helps a check
            test_data_in <= ~test_data_in;
            test_mode_sel <= ~test_mode_sel;
            if (go) begin
                busy <= 1'b1;
                ph <= 3'h0;
                k <= 4'h0;
            end
        end else begin
            ph <= ph + 3'h1;
            if (ph == 3'h0) begin
                test_data_in <= use_tdi & qual[k];
                test_mode_sel <= ~use_tdi & qual[k];
            end
            if (ph == 3'h2)
                test_clk <= 1'b1;
            if (ph == 3'h6)
                test_clk <= 1'b0;
            if (ph == 3'h7) begin
                k <= k + 4'h1;
                if (k == n_rises - 4'h1)
                    busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/jtg_gate_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module jtg_gate_top_tb;
    logic        pclk, presetn, ce, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, test_clk, test_data_in, test_mode_sel;
    logic        boot_nonsecure, fuse_port_disable, tap_in_reset;
    logic        tap_ir_load, user_debug_reach, force_bypass, id_available;
    logic        tamper_alert, tamper_response, global_output_tristate, irq;
    logic [3:0]  path_open, n_rises;
    logic [7:0]  qual;
    logic        go, use_tdi, busy;
    logic [31:0] q, d;
    logic        e;
    int          fails, num_checks, resp_cnt;

    jtg_gate_top i_jtg_gate_top (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .test_clk(test_clk),
        .test_data_in(test_data_in), .test_mode_sel(test_mode_sel),
        .boot_nonsecure(boot_nonsecure),
        .fuse_port_disable(fuse_port_disable),
        .tap_in_reset(tap_in_reset), .tap_ir_load(tap_ir_load),
        .path_open(path_open), .user_debug_reach(user_debug_reach),
        .force_bypass(force_bypass), .id_available(id_available),
        .tamper_alert(tamper_alert), .tamper_response(tamper_response),
        .global_output_tristate(global_output_tristate), .irq(irq));

    jtg_probe i_jtg_probe (.pclk(pclk), .go(go), .n_rises(n_rises),
        .qual(qual), .use_tdi(use_tdi), .test_clk(test_clk),
        .test_data_in(test_data_in), .test_mode_sel(test_mode_sel),
        .busy(busy));

    always #5 pclk = ~pclk;

    always @(posedge pclk)
        if (tamper_response === 1'b1)
            resp_cnt++;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            fails++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask

    task automatic frame(input logic [3:0] n, input logic [7:0] qm);
        int t;
        t = 0;
        n_rises <= n;
        qual <= qm;
        use_tdi <= 1'($urandom_range(0, 1));
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (busy === 1'b1 && t < 200) begin
            @(posedge pclk);
            t++;
        end
        if (t >= 200) begin
            fails++;
            end_of_test();
        end
        // pin synchroniser latency plus the alert edge
        repeat (12) @(posedge pclk);
    endtask

    task automatic do_reset(input logic bn);
        presetn <= 1'b0;
        boot_nonsecure <= bn;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, go, use_tdi} = 5'h00;
        {paddr, qual, n_rises} = 20'h00000;
        pwdata = 32'h0;
        {boot_nonsecure, fuse_port_disable} = 2'h0;
        {tap_in_reset, tap_ir_load} = 2'h0;
        {fails, num_checks, resp_cnt} = {32'sd0, 32'sd0, 32'sd0};
        void'($urandom(65931));
        do_reset(1'b0);
        rd(jtg_pkg::OFF_GATE, 32'h0000000F, "gate_rst");
        rd(jtg_pkg::OFF_PORT, 32'h0, "port_rst");
        rd(jtg_pkg::OFF_TAMPER, 32'h0, "tcfg_rst");
        rd(jtg_pkg::OFF_INT_MASK, 32'h0, "mask_rst");
        chk("path_rst", path_open, 32'h0);
        rd(8'h40, 32'h0, "unmapped_data");
        chk("unmapped_err", e, 32'h1);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            wr(jtg_pkg::OFF_INT_MASK, d);
            rd(jtg_pkg::OFF_INT_MASK, d & 32'h3, "mask_rw");
        end
        wr(jtg_pkg::OFF_INT_MASK, 32'h0);
        frame(4'h4, 8'hFF);
        chk("alert_det_off", tamper_alert, 32'h0);
        wr(jtg_pkg::OFF_TAMPER, 32'h1);
        wr(jtg_pkg::OFF_PORT, 32'h1);
        wr(jtg_pkg::OFF_GATE, 32'h8);
        chk("path_user_gated", path_open, 32'h7);
        chk("user_hidden", user_debug_reach, 32'h0);
        frame(4'h4, 8'hFF);
        chk("alert_gate_open", tamper_alert, 32'h0);
        wr(jtg_pkg::OFF_GATE, 32'h7);
        chk("user_reach", user_debug_reach, 32'h1);
        wr(jtg_pkg::OFF_GATE, 32'hF);
        frame(4'h5, 8'h1B);
        chk("alert_restart", tamper_alert, 32'h0);
        frame(4'h1, 8'h01);
        chk("alert_third", tamper_alert, 32'h1);
        chk("no_resp", resp_cnt, 32'h0);
        chk("no_lock", global_output_tristate, 32'h0);
        rd(jtg_pkg::OFF_INT_STAT, 32'h1, "ist_alert");
        chk("irq_masked", irq, 32'h0);
        wr(jtg_pkg::OFF_INT_MASK, 32'h3);
        chk("irq_on", irq, 32'h1);
        wr(jtg_pkg::OFF_INT_STAT, 32'h1);
        chk("irq_clr", irq, 32'h0);
        wr(jtg_pkg::OFF_TAMPER, 32'h0);
        chk("alert_sticky", tamper_alert, 32'h1);
        apb(1'b0, jtg_pkg::OFF_STATUS, 32'h0);
        chk("status_alert", q[0], 32'h1);
        do_reset(1'b0);
        chk("alert_por", tamper_alert, 32'h0);
        wr(jtg_pkg::OFF_TAMPER, 32'h7);
        resp_cnt = 0;
        frame(4'h3, 8'h07);
        chk("alert_b", tamper_alert, 32'h1);
        chk("resp_once", resp_cnt, 32'h1);
        chk("lockdown", global_output_tristate, 32'h1);
        rd(jtg_pkg::OFF_INT_STAT, 32'h3, "ist_both");
        fuse_port_disable <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("bypass", force_bypass, 32'h1);
        wr(jtg_pkg::OFF_GATE, 32'h0);
        rd(jtg_pkg::OFF_GATE, 32'h0000000F, "gate_fused");
        chk("path_fused", path_open, 32'h0);
        tap_ir_load <= 1'b1;
        @(posedge pclk);
        tap_ir_load <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("id_gone", id_available, 32'h0);
        tap_in_reset <= 1'b1;
        @(posedge pclk);
        tap_in_reset <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("id_back", id_available, 32'h1);
        fuse_port_disable <= 1'b0;
        do_reset(1'b1);
        rd(jtg_pkg::OFF_PORT, 32'h1, "port_boot");
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("pready_ce", pready, 32'h0);
        ce <= 1'b1;
        end_of_test();
    end
endmodule
`default_nettype wire
